// file: rtl/fmx_ptr_unit.sv
// package and pointer step unit for the flag and memory transfer executor
`timescale 1ns/1ps
`default_nettype none
package fmx_pkg;
   // operation codes presented on op_code
   localparam logic [3:0] FMX_OP_NONE      = 4'h0;
   localparam logic [3:0] FMX_OP_TSTORE    = 4'h1; // bit_store_to_flag
   localparam logic [3:0] FMX_OP_TLOAD     = 4'h2; // bit_load_from_flag
   localparam logic [3:0] FMX_OP_FSET      = 4'h3; // flag set
   localparam logic [3:0] FMX_OP_FCLR      = 4'h4; // flag clear
   localparam logic [3:0] FMX_OP_LOAD_INC  = 4'h5; // indirect_load_op, inc
   localparam logic [3:0] FMX_OP_LOAD_DEC  = 4'h6; // indirect_load_op, dec
   localparam logic [3:0] FMX_OP_STORE_INC = 4'h7; // indirect_store_op, inc
   localparam logic [3:0] FMX_OP_STORE_DEC = 4'h8; // indirect_store_op, dec
   localparam logic [3:0] FMX_OP_DIRECT    = 4'h9; // direct_load_op
   // status_word bit positions
   localparam int FMX_C_POS = 0;
   localparam int FMX_Z_POS = 1;
   localparam int FMX_N_POS = 2;
   localparam int FMX_V_POS = 3;
   localparam int FMX_S_POS = 4;
   localparam int FMX_H_POS = 5;
   localparam int FMX_T_POS = 6;
   localparam int FMX_I_POS = 7;
   // reset values
   localparam logic [7:0]  FMX_STATUS_RST = 8'h00;
   localparam logic [7:0]  FMX_REG_RST    = 8'h00;
   localparam logic [15:0] FMX_ADDR_RST   = 16'h0000;
   // pointer selection and low-byte register index of each pair
   localparam logic [1:0] FMX_PTR_X = 2'h0;
   localparam logic [1:0] FMX_PTR_Y = 2'h1;
   localparam logic [1:0] FMX_PTR_Z = 2'h2;
   localparam logic [4:0] FMX_X_LO  = 5'h1a;
   localparam logic [4:0] FMX_Y_LO  = 5'h1c;
   localparam logic [4:0] FMX_Z_LO  = 5'h1e;
   localparam logic [15:0] FMX_PTR_STEP = 16'h0001;
   // execution states
   typedef enum logic {FMX_IDLE, FMX_MEM} fmx_state_t;
endpackage : fmx_pkg

module fmx_ptr_unit
   import fmx_pkg::*;
(
   // pointer in
   input  wire logic [15:0] ptr,
   input  wire logic        pre_dec,
   // address and written-back pointer
   output logic      [15:0] access_addr,
   output logic      [15:0] updated_ptr
);
   // full 16-bit step so carry crosses the byte boundary
   assign access_addr = pre_dec ? ptr - FMX_PTR_STEP : ptr;
   assign updated_ptr = pre_dec ? ptr - FMX_PTR_STEP : ptr + FMX_PTR_STEP;
endmodule : fmx_ptr_unit
`default_nettype wire

// file: rtl/fmx_exec.sv
// flag and memory transfer execution unit with its working registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - bit store copies source bit into transfer flag, one cycle, no other flag
// - bit load writes transfer flag into destination bit, one cycle
// - flag set forces exactly one chosen status flag high in one cycle
// - flag clear forces exactly one chosen status flag low in one cycle
// - load post-inc reads byte at pointer, then pointer plus one, two cycles
// - load pre-dec decrements pointer, then reads the new address, two cycles
// - store post-inc writes source at pointer, then pointer plus one
// - store pre-dec decrements pointer, then writes source there
// - direct load fetches byte at instruction address, two cycles, no flags
module fmx_exec
   import fmx_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // operation request
   input  wire logic        op_valid,
   input  wire logic [3:0]  op_code,
   input  wire logic [4:0]  reg_sel,
   input  wire logic [2:0]  bit_sel,
   input  wire logic [2:0]  flag_sel,
   input  wire logic [1:0]  ptr_sel,
   input  wire logic [15:0] direct_addr,
   // register preload and peek
   input  wire logic        ext_we,
   input  wire logic [4:0]  ext_sel,
   input  wire logic [7:0]  ext_data,
   input  wire logic [4:0]  peek_sel,
   output logic      [7:0]  peek_data_ff,
   // status
   output logic             busy_ff,
   output logic             done_ff,
   output logic      [7:0]  status_word_ff,
   // data memory
   output logic      [15:0] mem_addr_ff,
   output logic      [7:0]  mem_wdata_ff,
   output logic             mem_we_ff,
   output logic             mem_re_ff,
   input  wire logic [7:0]  mem_rdata
);
   logic [7:0]  regs_ff [32];
   fmx_state_t  state_ff;
   logic        pend_load_ff;
   logic [4:0]  load_dst_ff;
   logic        take;
   logic        is_ptr_op;
   logic        is_pre_dec;
   logic [4:0]  lo_idx;
   logic [4:0]  hi_idx;
   logic [15:0] ptr_val;
   logic [15:0] access_addr;
   logic [15:0] updated_ptr;
   logic        sel_bit;

   // low register of the chosen pointer pair
   function automatic logic [4:0] ptr_lo_index(input logic [1:0] sel);
      unique case (sel)
         FMX_PTR_X: ptr_lo_index = FMX_X_LO;
         FMX_PTR_Y: ptr_lo_index = FMX_Y_LO;
         default:   ptr_lo_index = FMX_Z_LO;
      endcase
   endfunction : ptr_lo_index

   // request decode
   assign take       = op_valid && !busy_ff;
   assign is_pre_dec = (op_code == FMX_OP_LOAD_DEC) ||
                       (op_code == FMX_OP_STORE_DEC);
   assign is_ptr_op  = (op_code == FMX_OP_LOAD_INC) || is_pre_dec ||
                       (op_code == FMX_OP_STORE_INC);
   assign lo_idx     = ptr_lo_index(ptr_sel);
   assign hi_idx     = lo_idx + 5'h01;
   assign ptr_val    = {regs_ff[hi_idx], regs_ff[lo_idx]};
   assign sel_bit    = regs_ff[reg_sel][bit_sel];

   fmx_ptr_unit u_ptr (
      .ptr         (ptr_val),
      .pre_dec     (is_pre_dec),
      .access_addr (access_addr),
      .updated_ptr (updated_ptr)
   );

   // sequencing: one-cycle ops finish at once, memory ops take a second
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_ff     <= FMX_IDLE;
         busy_ff      <= 1'b0;
         done_ff      <= 1'b0;
         pend_load_ff <= 1'b0;
         load_dst_ff  <= 5'h00;
      end else begin
         done_ff <= 1'b0;
         unique case (state_ff)
            FMX_IDLE: begin
               if (take && (is_ptr_op || op_code == FMX_OP_DIRECT)) begin
                  state_ff     <= FMX_MEM;
                  busy_ff      <= 1'b1;
                  load_dst_ff  <= reg_sel;
                  pend_load_ff <= (op_code == FMX_OP_LOAD_INC) ||
                                  (op_code == FMX_OP_LOAD_DEC) ||
                                  (op_code == FMX_OP_DIRECT);
               end else if (take && op_code != FMX_OP_NONE) begin
                  done_ff <= 1'b1; // single-cycle op
               end
            end
            FMX_MEM: begin
               state_ff     <= FMX_IDLE;
               busy_ff      <= 1'b0;
               done_ff      <= 1'b1;
               pend_load_ff <= 1'b0;
            end
         endcase
      end
   end

   // memory request, one cycle wide, on the same edge as the pointer write-back
   always_ff @(posedge mclk) begin
      if (reset) begin
         mem_addr_ff  <= FMX_ADDR_RST;
         mem_wdata_ff <= FMX_REG_RST;
         mem_we_ff    <= 1'b0;
         mem_re_ff    <= 1'b0;
      end else begin
         mem_we_ff <= 1'b0;
         mem_re_ff <= 1'b0;
         if (take && is_ptr_op) begin
            mem_addr_ff  <= access_addr;
            mem_wdata_ff <= regs_ff[reg_sel];
            mem_we_ff    <= (op_code == FMX_OP_STORE_INC) ||
                            (op_code == FMX_OP_STORE_DEC);
            mem_re_ff    <= (op_code == FMX_OP_LOAD_INC) ||
                            (op_code == FMX_OP_LOAD_DEC);
         end else if (take && op_code == FMX_OP_DIRECT) begin
            mem_addr_ff <= direct_addr;
            mem_re_ff   <= 1'b1;
         end
      end
   end

   // working registers: preload, bit load, pointer write-back, load data
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < 32; i++) begin
            regs_ff[i] <= FMX_REG_RST;
         end
      end else begin
         if (ext_we && !busy_ff) begin
            regs_ff[ext_sel] <= ext_data;
         end
         if (take && op_code == FMX_OP_TLOAD) begin
            regs_ff[reg_sel][bit_sel] <= status_word_ff[FMX_T_POS];
         end
         if (take && is_ptr_op) begin
            regs_ff[lo_idx] <= updated_ptr[7:0];
            regs_ff[hi_idx] <= updated_ptr[15:8];
         end
         if (state_ff == FMX_MEM && pend_load_ff) begin
            regs_ff[load_dst_ff] <= mem_rdata;
         end
      end
   end

   // status word: only bit ops touch it, memory ops leave it alone
   always_ff @(posedge mclk) begin
      if (reset) begin
         status_word_ff <= FMX_STATUS_RST;
      end else if (take) begin
         unique case (op_code)
            FMX_OP_TSTORE: status_word_ff[FMX_T_POS] <= sel_bit;
            FMX_OP_FSET: status_word_ff[flag_sel]  <= 1'b1;
            FMX_OP_FCLR: status_word_ff[flag_sel]  <= 1'b0;
            default:     status_word_ff            <= status_word_ff;
         endcase
      end
   end

   // register peek port
   always_ff @(posedge mclk) begin
      if (reset) begin
         peek_data_ff <= FMX_REG_RST;
      end else begin
         peek_data_ff <= regs_ff[peek_sel];
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_tstore_copy: assert property (take && op_code == FMX_OP_TSTORE |=>
      status_word_ff[FMX_T_POS] == $past(sel_bit) &&
      status_word_ff[5:0] == $past(status_word_ff[5:0]) &&
      status_word_ff[7] == $past(status_word_ff[7]) && done_ff)
      else $error("bit store wrong");
   a_tload_write: assert property (take && op_code == FMX_OP_TLOAD |=>
      regs_ff[$past(reg_sel)][$past(bit_sel)] ==
      $past(status_word_ff[FMX_T_POS]) &&
      status_word_ff == $past(status_word_ff))
      else $error("bit load wrong");
   a_flag_set: assert property (take && op_code == FMX_OP_FSET |=>
      status_word_ff == ($past(status_word_ff) |
                         (8'h01 << $past(flag_sel))))
      else $error("flag set wrong");
   a_flag_clear: assert property (take && op_code == FMX_OP_FCLR |=>
      status_word_ff == ($past(status_word_ff) &
                         ~(8'h01 << $past(flag_sel))))
      else $error("flag clear wrong");
   a_load_inc_seq: assert property (
      take && op_code == FMX_OP_LOAD_INC |=>
      mem_re_ff && !mem_we_ff && mem_addr_ff == $past(ptr_val) && busy_ff
      ##1 done_ff && !busy_ff &&
      regs_ff[$past(reg_sel, 2)] == $past(mem_rdata))
      else $error("load post-inc wrong");
   a_load_dec_addr: assert property (
      take && op_code == FMX_OP_LOAD_DEC |=>
      mem_re_ff && mem_addr_ff == $past(ptr_val) - 16'h0001
      ##1 done_ff && regs_ff[$past(reg_sel, 2)] == $past(mem_rdata))
      else $error("load pre-dec wrong");
   a_store_inc_data: assert property (
      take && op_code == FMX_OP_STORE_INC |=>
      mem_we_ff && mem_addr_ff == $past(ptr_val) &&
      mem_wdata_ff == $past(regs_ff[reg_sel]) &&
      status_word_ff == $past(status_word_ff) ##1 done_ff)
      else $error("store post-inc wrong");
   a_store_dec_addr: assert property (
      take && op_code == FMX_OP_STORE_DEC |=>
      mem_we_ff && mem_addr_ff == $past(ptr_val) - 16'h0001 ##1 done_ff)
      else $error("store pre-dec wrong");
   a_direct_fetch: assert property (
      take && op_code == FMX_OP_DIRECT |=>
      mem_re_ff && mem_addr_ff == $past(direct_addr) ##1 done_ff &&
      regs_ff[$past(reg_sel, 2)] == $past(mem_rdata))
      else $error("direct load wrong");
   a_ptr_carry: assert property (
      take && op_code == FMX_OP_STORE_INC &&
      reg_sel != lo_idx && reg_sel != hi_idx |=>
      {regs_ff[$past(hi_idx)], regs_ff[$past(lo_idx)]} ==
      $past(ptr_val) + 16'h0001)
      else $error("pointer step wrong");

   c_load_carry: cover property (take && op_code == FMX_OP_LOAD_INC &&
      ptr_val[7:0] == 8'hff);
   c_store_dec: cover property (take && op_code == FMX_OP_STORE_DEC ##2
      take);
   c_tstore_tload: cover property (take && op_code == FMX_OP_TSTORE ##1
      take && op_code == FMX_OP_TLOAD);
   c_direct: cover property (take && op_code == FMX_OP_DIRECT ##1 op_valid);
endmodule : fmx_exec
`default_nettype wire

// file: bench/fmx_mem_model.sv
// data memory model facing the executor
`timescale 1ns/1ps
`default_nettype none
module fmx_mem_model (
   // clock
   input  wire logic        mclk,
   // memory port
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic        mem_we,
   input  wire logic        mem_re,
   output logic      [7:0]  mem_rdata
);
   logic [7:0] mem [0:255];
   // known fill so reads have predictable contents
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'ha5;
      end
   end
   // byte write while the write strobe stands
   always @(posedge mclk) begin
      if (mem_we) begin
         mem[mem_addr[7:0]] <= mem_wdata;
      end
   end
   // outside a read the data lines show garbage, not the last byte
   assign mem_rdata = mem_re ? mem[mem_addr[7:0]] : ~mem[mem_addr[7:0]];
endmodule : fmx_mem_model
`default_nettype wire

// file: bench/tb.sv
// self-checking testbench for the flag and memory transfer executor
`timescale 1ns/1ps
`default_nettype none
module tb import fmx_pkg::*; ;
   logic mclk, reset, op_valid, ext_we, busy_ff, done_ff, mem_we_ff, mem_re_ff;
   logic [3:0]  op_code;
   logic [4:0]  reg_sel, ext_sel, peek_sel;
   logic [2:0]  bit_sel, flag_sel;
   logic [1:0]  ptr_sel;
   logic [15:0] direct_addr, mem_addr_ff;
   logic [7:0]  ext_data, peek_data_ff, status_word_ff, mem_wdata_ff, mem_rdata;
   logic [7:0]  v;
   logic [7:0]  e;
   int          n_errors, num_checks;
   fmx_exec fmx_exec_i (.mclk(mclk), .reset(reset), .op_valid(op_valid),
      .op_code(op_code), .reg_sel(reg_sel), .bit_sel(bit_sel),
      .flag_sel(flag_sel), .ptr_sel(ptr_sel), .direct_addr(direct_addr),
      .ext_we(ext_we), .ext_sel(ext_sel), .ext_data(ext_data),
      .peek_sel(peek_sel), .peek_data_ff(peek_data_ff), .busy_ff(busy_ff),
      .done_ff(done_ff), .status_word_ff(status_word_ff),
      .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff),
      .mem_we_ff(mem_we_ff), .mem_re_ff(mem_re_ff), .mem_rdata(mem_rdata));
   fmx_mem_model fmx_mem_model_i (.mclk(mclk), .mem_addr(mem_addr_ff),
      .mem_wdata(mem_wdata_ff), .mem_we(mem_we_ff), .mem_re(mem_re_ff),
      .mem_rdata(mem_rdata));
   // 125 MHz clock
   always #4 mclk = ~mclk;
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         n_errors++;
      end
   endtask : chk
   // one request, then a bounded wait for done and a latency check
   task automatic run_op(input logic [3:0] code, input logic [4:0] rs,
      input logic [2:0] bs, input logic [1:0] ps, input logic [15:0] da,
      input int lat);
      int n;
      @(posedge mclk);
      op_valid <= 1'b1;
      op_code <= code;
      reg_sel <= rs;
      bit_sel <= bs;
      flag_sel <= bs;
      ptr_sel <= ps;
      direct_addr <= da;
      @(posedge mclk);
      op_valid <= 1'b0;
      #1;
      n = 1;
      while (done_ff !== 1'b1 && n < 4) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 4) begin
         $display("unexpected done: expected pulse, seen none");
         n_errors++;
         print_verdict();
      end
      chk("latency", 16'(lat), 16'(n));
      chk("busy", 16'h0000, 16'(busy_ff));
   endtask : run_op
   task automatic wr(input logic [4:0] s, input logic [7:0] d);
      @(posedge mclk);
      ext_we <= 1'b1;
      ext_sel <= s;
      ext_data <= d;
      @(posedge mclk);
      ext_we <= 1'b0;
   endtask : wr
   task automatic peek(input logic [4:0] s, output logic [7:0] d);
      @(posedge mclk);
      peek_sel <= s;
      @(posedge mclk);
      #1;
      d = peek_data_ff;
   endtask : peek
   task automatic chk_ptr(input logic [4:0] lo, input logic [15:0] exp);
      logic [7:0] l, h;
      peek(lo, l);
      peek(lo + 5'h1, h);
      chk("pointer", exp, {h, l});
   endtask : chk_ptr
   // set all flags in turn, then clear them in turn
   task automatic t_flags();
      e = 8'h00;
      for (int f = 0; f < 8; f++) begin
         e[f] = 1'b1;
         run_op(FMX_OP_FSET, 5'h0, 3'(f), 2'h0, 16'h0, 1);
         chk("status", 16'(e), 16'(status_word_ff));
      end
      for (int f = 0; f < 8; f++) begin
         e[f] = 1'b0;
         run_op(FMX_OP_FCLR, 5'h0, 3'(f), 2'h0, 16'h0, 1);
         chk("status", 16'(e), 16'(status_word_ff));
      end
      $display("test flags done");
   endtask : t_flags
   // transfer bit to and from the status word
   task automatic t_bits();
      wr(5'h03, 8'h20);
      run_op(FMX_OP_TSTORE, 5'h03, 3'h5, 2'h0, 16'h0, 1);
      chk("status", 16'h0040, 16'(status_word_ff));
      run_op(FMX_OP_TLOAD, 5'h04, 3'h2, 2'h0, 16'h0, 1);
      chk("status", 16'h0040, 16'(status_word_ff));
      peek(5'h04, v);
      chk("r4", 16'h0004, 16'(v));
      run_op(FMX_OP_TSTORE, 5'h03, 3'h0, 2'h0, 16'h0, 1);
      chk("status", 16'h0000, 16'(status_word_ff));
      $display("test bits done");
   endtask : t_bits
   // loads across the byte boundary of a pointer, then one direct load
   task automatic t_loads();
      wr(FMX_X_LO, 8'hff);
      run_op(FMX_OP_LOAD_INC, 5'h01, 3'h0, FMX_PTR_X, 16'h0, 2);
      peek(5'h01, v);
      chk("r1", 16'h005a, 16'(v));
      chk_ptr(FMX_X_LO, 16'h0100);
      wr(FMX_Y_LO + 5'h1, 8'h01);
      run_op(FMX_OP_LOAD_DEC, 5'h02, 3'h0, FMX_PTR_Y, 16'h0, 2);
      chk("address", 16'h00ff, mem_addr_ff);
      peek(5'h02, v);
      chk("r2", 16'h005a, 16'(v));
      chk_ptr(FMX_Y_LO, 16'h00ff);
      run_op(FMX_OP_DIRECT, 5'h07, 3'h0, 2'h0, 16'h1234, 2);
      peek(5'h07, v);
      chk("r7", 16'h0091, 16'(v));
      chk("status", 16'h0000, 16'(status_word_ff));
      $display("test loads done");
   endtask : t_loads
   // stores with pointer steps crossing a byte boundary
   task automatic t_stores();
      wr(5'h05, 8'h3c);
      wr(5'h06, 8'hc3);
      wr(FMX_Z_LO, 8'hff);
      wr(FMX_Z_LO + 5'h1, 8'h01);
      run_op(FMX_OP_STORE_INC, 5'h05, 3'h0, FMX_PTR_Z, 16'h0, 2);
      chk("mem", 16'h003c, 16'(fmx_mem_model_i.mem[8'hff]));
      chk_ptr(FMX_Z_LO, 16'h0200);
      run_op(FMX_OP_STORE_DEC, 5'h06, 3'h0, FMX_PTR_Z, 16'h0, 2);
      chk("address", 16'h01ff, mem_addr_ff);
      chk("mem", 16'h00c3, 16'(fmx_mem_model_i.mem[8'hff]));
      chk("status", 16'h0000, 16'(status_word_ff));
      chk_ptr(FMX_Z_LO, 16'h01ff);
      $display("test stores done");
   endtask : t_stores
   // reset, then the scenarios in turn
   initial begin
      {mclk, op_valid, ext_we, op_code, reg_sel, ext_sel, peek_sel} = '0;
      {bit_sel, flag_sel, ptr_sel, direct_addr, ext_data} = '0;
      {n_errors, num_checks} = '0;
      reset = 1'b1;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      t_flags();
      t_bits();
      t_loads();
      t_stores();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
